//--- verilog/aq_ctrl_pkg.sv
`default_nettype none
package aq_ctrl_pkg;
    localparam int NUM_QUADS = 10;
    localparam int PAD_TYPES = 3;
    localparam int CODE_W = 12;
    localparam int IDX_W = 4;
    localparam int DATA_W = 32;
    localparam int DIGIN_MAX_MHZ = 10;
    localparam int CLK_MHZ = 25;
    // Pad settle wait: shortest legal digital period in cycles (floor, min 1)
    localparam int DIGIN_CYC_RAW = CLK_MHZ / DIGIN_MAX_MHZ;
    localparam int DIGIN_CYC = (DIGIN_CYC_RAW < 1) ? 1 : DIGIN_CYC_RAW;
    localparam int CM_GAIN = 10;
    localparam int GATE_LEVEL_W = 2;
    localparam int GATE_SINK_MA = 20;
    localparam int GATE_TON_NS = 100;
    localparam int GATE_TOFF_NS = 600;
    localparam int CLK_PERIOD_NS = 40;
    localparam int GATE_TOFF_CYC = (GATE_TOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Wishbone register byte addresses
    localparam logic [7:0] ADDR_DIGIN_EN   = 8'h00;
    localparam logic [7:0] ADDR_DIGIN_LVL  = 8'h04;
    localparam logic [7:0] ADDR_GATE_ON    = 8'h08;
    localparam logic [7:0] ADDR_GATE_HI    = 8'h0C;
    localparam logic [7:0] ADDR_GATE_LEVEL = 8'h10;
    localparam logic [7:0] ADDR_CM_SEL     = 8'h14;
    localparam logic [7:0] ADDR_CM_CODE    = 8'h18;
    localparam logic [7:0] ADDR_CM_ID      = 8'h1C;
    localparam logic [DATA_W-1:0] CM_ID_VALUE = 32'h0000A5C3; // Arbitrary value
    localparam logic [CODE_W-1:0] CODE_FULL = 12'hFFF;
    localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h00000000;
endpackage
`default_nettype wire

//--- verilog/cm_code_mem.sv
`timescale 1ns/1ns
`default_nettype none
// Latest current code per quad; registered read data
module cm_code_mem
    import aq_ctrl_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              we_i,
    input  wire logic [IDX_W-1:0]  waddr_i,
    input  wire logic [CODE_W-1:0] wdata_i,
    input  wire logic [IDX_W-1:0]  raddr_i,
    output var  logic [CODE_W-1:0] rdata_o
);
    logic [CODE_W-1:0] mem [NUM_QUADS];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule // cm_code_mem
`default_nettype wire

//--- verilog/analog_quad_control.sv
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module analog_quad_control
    import aq_ctrl_pkg::*;
#(
    parameter int STROBE_LOW_MIN_CYC   = 4,
    parameter int STROBE_SETUP_MIN_CYC = 4,
    parameter int STROBE_HIGH_MIN_CYC  = 4
) (
    input  wire logic                 core_clk_i,
    input  wire logic                 arst_n_i,
    // Wishbone classic slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [DATA_W-1:0]    wb_dat_i,
    output var  logic [DATA_W-1:0]    wb_dat_o,
    output var  logic                 wb_ack_o,
    // Raw pad levels as seen by the input comparators, {T,C,V} per quad
    input  wire logic [NUM_QUADS-1:0] voltage_pad_i,
    input  wire logic [NUM_QUADS-1:0] current_pad_i,
    input  wire logic [NUM_QUADS-1:0] temperature_pad_i,
    output var  logic [NUM_QUADS-1:0] pad_digital_level_out_v_o,
    output var  logic [NUM_QUADS-1:0] pad_digital_level_out_c_o,
    output var  logic [NUM_QUADS-1:0] pad_digital_level_out_t_o,
    // Current monitor path
    input  wire logic                 sample_i,
    input  wire logic                 conv_done_i,
    input  wire logic [CODE_W-1:0]    amp_code_i,
    input  wire logic                 amp_over_i,
    input  wire logic                 amp_neg_i,
    output var  logic                 current_measure_strobe_o,
    output var  logic                 conversion_start_o,
    output var  logic [IDX_W-1:0]     cm_quad_o,
    output var  logic                 cm_busy_o,
    // Gate pads (open drain style)
    output var  logic [NUM_QUADS-1:0] gate_pad_o,
    output var  logic [NUM_QUADS-1:0] gate_pad_oe_o,
    output var  logic [NUM_QUADS-1:0] gate_high_current_o,
    output var  logic [2*NUM_QUADS-1:0] gate_level_o
);
    typedef enum logic [2:0] {S_IDLE, S_LOW, S_SETUP, S_START, S_HOLD, S_WAIT} cm_state_e;
    function automatic logic [15:0] cyc16(input int n);
        cyc16 = n[15:0];
    endfunction
    // Register state
    logic [3*NUM_QUADS-1:0] den_q, den_d;
    logic [NUM_QUADS-1:0]   gon_q, gon_d, ghi_q, ghi_d;
    logic [2*NUM_QUADS-1:0] glv_q, glv_d;
    logic [IDX_W-1:0]       sel_q, sel_d;
    logic                   go_q, go_d;
    logic                   ack_q, ack_d;
    logic [DATA_W-1:0]      rd_q, rd_d;
    logic [CODE_W-1:0]      mem_rdata;
    logic [CODE_W-1:0]      cm_code_q, cm_code_d;
    logic                   cm_sat_q, cm_sat_d;
    logic                   req;
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    always_comb begin
        den_d = den_q;
        gon_d = gon_q;
        ghi_d = ghi_q;
        glv_d = glv_q;
        sel_d = sel_q;
        go_d  = 1'b0;
        ack_d = req;
        rd_d  = UNMAPPED_READ;
        if (req && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                ADDR_DIGIN_EN: den_d = wb_dat_i[3*NUM_QUADS-1:0];
                ADDR_GATE_ON:  gon_d = wb_dat_i[NUM_QUADS-1:0];
                ADDR_GATE_HI:  ghi_d = wb_dat_i[NUM_QUADS-1:0];
                ADDR_GATE_LEVEL: glv_d = wb_dat_i[2*NUM_QUADS-1:0];
                ADDR_CM_SEL: begin
                    if (wb_dat_i[IDX_W-1:0] < IDX_W'(NUM_QUADS)) begin
                        sel_d = wb_dat_i[IDX_W-1:0];
                        go_d  = wb_dat_i[8];
                    end
                end
                default: ;
            endcase
        end
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                ADDR_DIGIN_EN:   rd_d = DATA_W'(den_q);
                ADDR_DIGIN_LVL:  rd_d = DATA_W'({pad_digital_level_out_t_o,
                                        pad_digital_level_out_c_o, pad_digital_level_out_v_o});
                ADDR_GATE_ON:    rd_d = DATA_W'(gon_q);
                ADDR_GATE_HI:    rd_d = DATA_W'(ghi_q);
                ADDR_GATE_LEVEL: rd_d = DATA_W'(glv_q);
                ADDR_CM_SEL:     rd_d = DATA_W'({cm_busy_o, 11'h000, sel_q});
                ADDR_CM_CODE:    rd_d = DATA_W'({cm_sat_q, 3'h0, cm_code_q});
                ADDR_CM_ID:      rd_d = CM_ID_VALUE;
                default:         rd_d = UNMAPPED_READ;
            endcase
        end
    end
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            den_q <= '0;
            gon_q <= '0;
            ghi_q <= '0;
            glv_q <= '0;
            sel_q <= '0;
            go_q  <= 1'b0;
            ack_q <= 1'b0;
            rd_q  <= '0;
        end else begin
            den_q <= den_d;
            gon_q <= gon_d;
            ghi_q <= ghi_d;
            glv_q <= glv_d;
            sel_q <= sel_d;
            go_q  <= go_d;
            ack_q <= ack_d;
            rd_q  <= rd_d;
        end
    end
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rd_q;
    // Digital input path: registered, gated by enable; independent of the monitor
    logic [NUM_QUADS-1:0] lv_d, lc_d, lt_d;
    always_comb begin
        lv_d = voltage_pad_i & den_q[NUM_QUADS-1:0];
        lc_d = current_pad_i & den_q[2*NUM_QUADS-1:NUM_QUADS];
        lt_d = temperature_pad_i & den_q[3*NUM_QUADS-1:2*NUM_QUADS];
    end
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pad_digital_level_out_v_o <= '0;
            pad_digital_level_out_c_o <= '0;
            pad_digital_level_out_t_o <= '0;
        end else begin
            pad_digital_level_out_v_o <= lv_d;
            pad_digital_level_out_c_o <= lc_d;
            pad_digital_level_out_t_o <= lt_d;
        end
    end
    // Gate drive; pad pulled low while on, released otherwise
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gate_pad_oe_o       <= '0;
            gate_high_current_o <= '0;
            gate_level_o        <= '0;
        end else begin
            gate_pad_oe_o       <= gon_q;
            gate_high_current_o <= ghi_q;
            gate_level_o        <= glv_q;
        end
    end
    assign gate_pad_o = '0;

    // Strobe sequencer
    cm_state_e st_q, st_d;
    logic [15:0] cnt_q, cnt_d;
    logic stb_q, stb_d, start_q, start_d, busy_q, busy_d;
    logic wr_en;
    // Strobe run lengths for the timing checks; saturate so a long idle cannot wrap
    logic [15:0] lo_run_q, lo_run_d, hi_run_q, hi_run_d;
    always_comb begin
        st_d      = st_q;
        lo_run_d  = stb_q ? '0 : lo_run_q + {15'h0000, ~&lo_run_q};
        hi_run_d  = stb_q ? hi_run_q + {15'h0000, ~&hi_run_q} : '0;
        cnt_d     = cnt_q + 16'h0001;
        stb_d     = stb_q;
        start_d   = 1'b0;
        busy_d    = busy_q;
        cm_code_d = cm_code_q;
        cm_sat_d  = cm_sat_q;
        wr_en     = 1'b0;
        case (st_q)
            S_IDLE: begin
                if (go_q) begin
                    st_d = S_LOW;
                    stb_d = 1'b0;
                    busy_d = 1'b1;
                    cnt_d = 16'h0001;
                end
            end
            S_LOW: begin
                if (cnt_q >= cyc16(STROBE_LOW_MIN_CYC)) begin
                    st_d = S_SETUP;
                    stb_d = 1'b1;
                    cnt_d = 16'h0001;
                end
            end
            S_SETUP: begin
                if (cnt_q >= cyc16(STROBE_SETUP_MIN_CYC)) begin
                    st_d = S_START;
                    start_d = 1'b1;
                end
            end
            S_START: st_d = S_HOLD;
            S_HOLD: begin
                if (!sample_i && cnt_q >= cyc16(STROBE_HIGH_MIN_CYC)) begin
                    st_d = S_WAIT;
                    stb_d = 1'b0;
                end
            end
            S_WAIT: begin
                if (conv_done_i) begin
                    // Saturate over-range, clamp reverse polarity to zero
                    cm_sat_d  = amp_over_i;
                    cm_code_d = amp_over_i ? CODE_FULL :
                                (amp_neg_i ? CODE_ZERO : amp_code_i);
                    wr_en  = 1'b1;
                    busy_d = 1'b0;
                    st_d   = S_IDLE;
                end
            end
            default: st_d = S_IDLE;
        endcase
    end
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_q <= S_IDLE;
            cnt_q <= '0;
            stb_q <= 1'b1;
            start_q <= 1'b0;
            busy_q <= 1'b0;
            cm_code_q <= '0;
            cm_sat_q <= 1'b0;
            lo_run_q <= '0;
            hi_run_q <= '0;
        end else begin
            st_q <= st_d;
            lo_run_q <= lo_run_d;
            hi_run_q <= hi_run_d;
            cnt_q <= cnt_d;
            stb_q <= stb_d;
            start_q <= start_d;
            busy_q <= busy_d;
            cm_code_q <= cm_code_d;
            cm_sat_q <= cm_sat_d;
        end
    end
    assign current_measure_strobe_o = stb_q;
    assign conversion_start_o = start_q;
    assign cm_busy_o = busy_q;
    assign cm_quad_o = sel_q;

    // Per-quad archive of the latest code
    cm_code_mem u_mem (
        .clk_i   (core_clk_i),
        .we_i    (wr_en),
        .waddr_i (sel_q),
        .wdata_i (cm_code_d),
        .raddr_i (sel_q),
        .rdata_o (mem_rdata)
    );
    logic unused_rd;
    assign unused_rd = ^mem_rdata;

    chk_strobe_low_min: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        $rose(stb_q) && busy_q |-> lo_run_q >= cyc16(STROBE_LOW_MIN_CYC))
        else $error("strobe low too short");
    chk_start_after_setup: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        start_q |-> stb_q && hi_run_q >= cyc16(STROBE_SETUP_MIN_CYC))
        else $error("start without strobe setup");
    chk_strobe_hold: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        st_q == S_HOLD && sample_i |=> stb_q)
        else $error("strobe fell during sample");
    chk_code_saturate: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        st_q == S_WAIT && conv_done_i && amp_over_i |=> cm_code_q == CODE_FULL)
        else $error("code not saturated");
    chk_gate_follow: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        ##1 gate_pad_oe_o == $past(gon_q))
        else $error("gate enable mismatch");
    chk_digin_gate: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        ##1 pad_digital_level_out_v_o == $past(voltage_pad_i & den_q[NUM_QUADS-1:0]))
        else $error("digital level wrong");
    chk_wb_ack_once: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    chk_unipolar_zero: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
        st_q == S_WAIT && conv_done_i && amp_neg_i && !amp_over_i |=> cm_code_q == CODE_ZERO)
        else $error("negative not clamped");
endmodule // analog_quad_control
`default_nettype wire

//--- tb/aq_conv_model.sv
`timescale 1ns/1ns
`default_nettype none
// Converter and amplifier side of the analog block
module aq_conv_model #(
    parameter int SAMP = 4
) (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               start_i,
    input  wire logic signed [31:0] diff_i,
    input  wire logic [3:0]         lat_i,
    output var  logic               sample_o,
    output var  logic               done_o,
    output var  logic [11:0]        code_o,
    output var  logic               over_o,
    output var  logic               neg_o
);
    logic        busy;
    int          t;
    logic [11:0] pat;
    logic [31:0] mag;
    logic [31:0] sc;
    assign mag = diff_i[31] ? -diff_i : diff_i;
    assign sc = mag << 4;
    // Gain of ten on a 2560 mV reference: 16 codes per mV
    // Raw code wraps when over range; saturation is the block's job
    assign code_o = done_o ? sc[11:0] : pat;
    assign over_o = (diff_i > 255);
    assign neg_o = diff_i[31];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy <= 1'b0;
            t <= 0;
            sample_o <= 1'b0;
            done_o <= 1'b0;
            pat <= 12'h5A3;
        end else begin
            pat <= pat + 12'h3A5;
            done_o <= 1'b0;
            if (start_i && !busy) begin
                busy <= 1'b1;
                t <= 0;
                sample_o <= 1'b1; // Sample never shorter than SAMP
            end else if (busy) begin
                t <= t + 1;
                if (t == SAMP + int'(lat_i) - 1) sample_o <= 1'b0;
                if (t == SAMP + int'(lat_i) + 1) begin
                    done_o <= 1'b1;
                    busy <= 1'b0;
                end
            end
        end
    end
endmodule // aq_conv_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb_top;
    import aq_ctrl_pkg::*;
    localparam int LOW = 3;
    localparam int SET = 5;
    localparam int HI = 4;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h00000000, q, en, r, rs = 32'h00002C44;
    logic [9:0] vp = 10'h000, cp = 10'h000, tp = 10'h000;
    logic signed [31:0] diff = 32'sh0;
    logic [3:0] lat = 4'h0, quad;
    logic [11:0] acode, ec;
    logic [9:0] lv, lc, lt, gp, goe, ghc;
    logic [19:0] glv;
    logic [31:0] datw;
    logic ackw, sample, done, over, neg, strobe, start, busy, es;
    int error_cnt = 0, comparisons = 0, run = 0, starts = 0, n;
    logic ps = 1'b1;
    int dv[5] = '{100, 0, 255, 256, -50};
    int lt_q[5] = '{0, 3, 1, 5, 2};
    int qd[5] = '{0, 9, 4, 7, 2};
    always #20 core_clk = ~core_clk;
    analog_quad_control #(.STROBE_LOW_MIN_CYC(LOW), .STROBE_SETUP_MIN_CYC(SET),
        .STROBE_HIGH_MIN_CYC(HI)) uut (
        .core_clk_i(core_clk), .arst_n_i(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datw),
        .wb_ack_o(ackw), .voltage_pad_i(vp), .current_pad_i(cp), .temperature_pad_i(tp),
        .pad_digital_level_out_v_o(lv), .pad_digital_level_out_c_o(lc),
        .pad_digital_level_out_t_o(lt), .sample_i(sample), .conv_done_i(done),
        .amp_code_i(acode), .amp_over_i(over), .amp_neg_i(neg),
        .current_measure_strobe_o(strobe), .conversion_start_o(start), .cm_quad_o(quad),
        .cm_busy_o(busy), .gate_pad_o(gp), .gate_pad_oe_o(goe),
        .gate_high_current_o(ghc), .gate_level_o(glv));
    aq_conv_model #(.SAMP(HI)) conv (.clk_i(core_clk), .rst_n_i(arst_n), .start_i(start),
        .diff_i(diff), .lat_i(lat), .sample_o(sample), .done_o(done), .code_o(acode),
        .over_o(over), .neg_o(neg));
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        @(posedge core_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        // Ack and read data are taken at the rising edge that sees ack high
        do begin @(posedge core_clk); n++; end while (ackw !== 1'b1 && n < 50);
        if (n >= 50) error_cnt++;
        q = datw;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Strobe sequence watcher, sampled mid-cycle to stay clear of the edge
    always @(negedge core_clk) if (arst_n) begin
        if (start === 1'b1) begin
            starts++;
            `CHK("setup", 1'b1, strobe === 1'b1 && run >= SET)
        end
        if (strobe !== ps) begin
            if (ps) begin
                `CHK("hold", 1'b0, sample)
                `CHK("high", 1'b1, run >= HI)
            end else `CHK("low", 1'b1, run >= LOW)
            run = 0;
        end
        run++;
        ps = strobe;
    end
    initial begin
        #(40 * 40000);
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        @(negedge core_clk);
        `CHK("strobe_rst", 1'b1, strobe)
        xfer(1'b0, ADDR_CM_ID, 32'h0);
        `CHK("id", CM_ID_VALUE, q)
        xfer(1'b1, 8'h20, 32'hFFFFFFFF);
        xfer(1'b0, 8'h20, 32'h0);
        `CHK("unmapped", UNMAPPED_READ, q)
        repeat (4) begin
            en = rnd() & 32'h3FFFFFFF;
            xfer(1'b1, ADDR_DIGIN_EN, en);
            xfer(1'b0, ADDR_DIGIN_EN, 32'h0);
            `CHK("en_rd", en, q)
            r = rnd();
            @(posedge core_clk);
            vp <= r[9:0]; cp <= r[19:10]; tp <= r[29:20];
            repeat (DIGIN_CYC + 3) @(negedge core_clk);
            `CHK("dig_v", vp & en[9:0], lv)
            `CHK("dig_c", cp & en[19:10], lc)
            `CHK("dig_t", tp & en[29:20], lt)
            xfer(1'b0, ADDR_DIGIN_LVL, 32'h0);
            `CHK("lvl_rd", {2'b00, tp & en[29:20], cp & en[19:10], vp & en[9:0]}, q)
        end
        repeat (3) begin
            r = rnd();
            xfer(1'b1, ADDR_GATE_ON, {22'h0, r[9:0]});
            xfer(1'b1, ADDR_GATE_HI, {22'h0, r[19:10]});
            xfer(1'b1, ADDR_GATE_LEVEL, {12'h0, r[31:12]});
            @(negedge core_clk);
            `CHK("gate_oe", r[9:0], goe)
            `CHK("gate_pad", 10'h000, gp)
            `CHK("gate_hc", r[19:10], ghc)
            `CHK("gate_lvl", r[31:12], glv)
            // High-current gate needs its turn-off time before the next toggle
            repeat (2 * GATE_TOFF_CYC) @(posedge core_clk);
        end
        for (int i = 0; i < 5; i++) begin
            diff <= dv[i];
            lat <= 4'(lt_q[i]);
            xfer(1'b1, ADDR_CM_SEL, {23'h0, 1'b1, 4'h0, 4'(qd[i])});
            n = 0;
            do begin @(negedge core_clk); n++; end while (busy !== 1'b0 && n < 200);
            `CHK("cm_quad", 4'(qd[i]), quad)
            if (dv[i] < 0) begin ec = CODE_ZERO; es = 1'b0; end
            else if (dv[i] > 255) begin ec = CODE_FULL; es = 1'b1; end
            else begin ec = 12'(dv[i] * 16); es = 1'b0; end
            xfer(1'b0, ADDR_CM_CODE, 32'h0);
            `CHK("cm_code", {16'h0, es, 3'b000, ec}, q)
        end
        xfer(1'b1, ADDR_CM_SEL, 32'h0000010A);
        repeat (3) @(negedge core_clk);
        `CHK("bad_quad", 1'b0, busy)
        `CHK("bad_sel", 4'(qd[4]), quad)
        `CHK("starts", 5, starts)
        print_verdict();
    end
endmodule // tb_top
`undef CHK
`default_nettype wire
